// ---- prtec_dev_end.sv ----
// protocol-block end: formation, type, payload, tc map and credit checks
// assumes headers and credit updates arrive already decoded on mclk
`timescale 1ns/1ps

module prtec_dev_end (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  rx_vld,
    input  wire prtec_pkg::prtec_hdr_t rx_hdr,
    input  wire logic [2:0]            max_payload,
    input  wire logic [7:0]            tc_vc_en,
    input  wire logic                  fc_upd_vld,
    input  wire logic                  fc_upd_init,
    input  wire logic [7:0]            fc_hdr_lim,
    input  wire logic [11:0]           fc_data_lim,
    input  wire logic                  tx_hdr_use,
    input  wire logic [7:0]            tx_data_use,
    output logic                       fc_err,
    prtec_if.dev                       lnk
);

    // ****************************************************************
    // header checks
    // ****************************************************************
    logic                  vld_q, vld_d, mal_q, mal_d, uns_q, uns_d;
    prtec_pkg::prtec_hdr_t hdr_q, hdr_d;
    logic [12:0]           pay_b, mps_b;
    logic [2:0]            mps_c;
    logic                  cfg_io;

    // flags travel with the header so the user side can answer it
    always_comb begin
        mps_c = (max_payload > prtec_pkg::MPS_TOP) ? prtec_pkg::MPS_TOP
                                                   : max_payload;
        mps_b = prtec_pkg::MPS_BASE_B << mps_c;
        pay_b = {(rx_hdr.len == 10'h000), rx_hdr.len, 2'b00};
        cfg_io = (rx_hdr.typ == prtec_pkg::TYP_IO)
              || (rx_hdr.typ[4:1] == prtec_pkg::TYP_CFG0[4:1]);
        vld_d = rx_vld;
        hdr_d = rx_hdr;
        // config and io are one dword, 3dw, tc0 only
        mal_d = cfg_io && (rx_hdr.len != 10'h001
              || rx_hdr.tc != 3'h0 || rx_hdr.fmt[prtec_pkg::FMT_4DW]);
        if (rx_hdr.typ == prtec_pkg::TYP_CPL
                && rx_hdr.fmt[prtec_pkg::FMT_DAT] && pay_b > mps_b) begin
            mal_d = 1'b1;
        end
        if (!tc_vc_en[rx_hdr.tc]) begin
            mal_d = 1'b1;
        end
        // an endpoint takes no type 1 config and no trusted config
        uns_d = (rx_hdr.typ == prtec_pkg::TYP_CFG1)
             || (rx_hdr.typ == prtec_pkg::TYP_TCFG);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vld_q <= 1'b0;
            hdr_q <= '0;
            mal_q <= 1'b0;
            uns_q <= 1'b0;
        end else if (ce) begin
            vld_q <= vld_d;
            hdr_q <= hdr_d;
            mal_q <= mal_d;
            uns_q <= uns_d;
        end
    end

    assign lnk.vld   = vld_q;
    assign lnk.hdr   = hdr_q;
    assign lnk.mal   = mal_q;
    assign lnk.unsup = uns_q;

    // ****************************************************************
    // flow-control credit checks
    // ****************************************************************
    logic [7:0]  hcons_q, hcons_d;
    logic [11:0] dcons_q, dcons_d;
    logic        infh_q, infh_d, infd_q, infd_d, err_q, err_d;
    logic        fci_q, fci_d;
    logic [7:0]  fch_q, fch_d;
    logic [11:0] fcd_q, fcd_d;

    // outstanding credit is limit minus consumed, modulo the field width
    always_comb begin
        hcons_d = hcons_q + {7'h00, tx_hdr_use};
        dcons_d = dcons_q + {4'h0, tx_data_use};
        infh_d  = infh_q;
        infd_d  = infd_q;
        err_d   = 1'b0;
        fci_d   = fc_upd_vld && fc_upd_init;
        fch_d   = fc_upd_vld ? fc_hdr_lim : fch_q;
        fcd_d   = fc_upd_vld ? fc_data_lim : fcd_q;
        if (fc_upd_vld) begin
            if (fc_upd_init) begin
                infh_d = (fc_hdr_lim == 8'h00);
                infd_d = (fc_data_lim == 12'h000);
            end else if ((infh_q && fc_hdr_lim != 8'h00)
                      || (infd_q && fc_data_lim != 12'h000)) begin
                err_d = 1'b1;
            end
            if (!infh_d && 8'(fc_hdr_lim - hcons_q)
                    > prtec_pkg::HDR_OUT_MAX) begin
                err_d = 1'b1;
            end
            if (!infd_d && 12'(fc_data_lim - dcons_q)
                    > prtec_pkg::DAT_OUT_MAX) begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hcons_q <= 8'h00;
            dcons_q <= 12'h000;
            infh_q  <= 1'b0;
            infd_q  <= 1'b0;
            err_q   <= 1'b0;
            fci_q   <= 1'b0;
            fch_q   <= 8'h00;
            fcd_q   <= 12'h000;
        end else if (ce) begin
            hcons_q <= hcons_d;
            dcons_q <= dcons_d;
            infh_q  <= infh_d;
            infd_q  <= infd_d;
            err_q   <= err_d;
            fci_q   <= fci_d;
            fch_q   <= fch_d;
            fcd_q   <= fcd_d;
        end
    end

    assign fc_err       = err_q;
    assign lnk.fci_vld  = fci_q;
    assign lnk.fci_hdr  = fch_q;
    assign lnk.fci_data = fcd_q;

endmodule

// ---- prtec_if.sv ----
// link between the protocol block and the user application logic
// assumes both ends share mclk, rst_n and the clock enable
`timescale 1ns/1ps

interface prtec_if;

    // ****************************************************************
    // received tlp with the flags raised by the protocol block
    // ****************************************************************
    logic                  vld;    // one-cycle pulse per header
    prtec_pkg::prtec_hdr_t hdr;
    logic                  mal;    // malformed by the protocol block
    logic                  unsup;  // unsupported request type

    // ****************************************************************
    // initial flow-control advertisement of the link partner
    // ****************************************************************
    logic                  fci_vld;
    logic [7:0]            fci_hdr;
    logic [11:0]           fci_data;

    modport dev (output vld, hdr, mal, unsup, fci_vld, fci_hdr, fci_data);
    modport usr (input  vld, hdr, mal, unsup, fci_vld, fci_hdr, fci_data);

endinterface

// ---- prtec_monitor.sv ----
// checker on the protocol-block side of the received tlp link
// assumes it sits beside prtec_if and sees the block's input pins
`timescale 1ns/1ps

module prtec_monitor (
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic                  ce,
    input wire logic                  rx_vld,
    input wire prtec_pkg::prtec_hdr_t rx_hdr,
    input wire logic [2:0]            max_payload,
    input wire logic [7:0]            tc_vc_en,
    input wire logic                  fc_upd_vld,
    input wire logic                  fc_upd_init,
    input wire logic [7:0]            fc_hdr_lim,
    input wire logic                  tx_hdr_use,
    input wire logic                  fc_err,
    input wire logic                  vld,
    input wire prtec_pkg::prtec_hdr_t hdr,
    input wire logic                  mal,
    input wire logic                  unsup,
    input wire logic                  fci_vld,
    input wire logic [7:0]            fci_hdr
);
    // ****************************************************************
    // header credit shadow
    // ****************************************************************
    logic [7:0] hc_q;
    logic [7:0] hc_d;
    logic       inf_q;
    logic       inf_d;
    logic [7:0] left;
    logic       upd;
    logic       fin;

    // mirrors header credit use
    always_comb begin
        upd   = ce && fc_upd_vld;
        hc_d  = hc_q + {7'h00, ce && tx_hdr_use};
        inf_d = (upd && fc_upd_init) ? (fc_hdr_lim == 8'h00) : inf_q;
        fin   = fc_upd_init ? (fc_hdr_lim != 8'h00) : !inf_q;
        left  = fc_hdr_lim - hc_q;  // wraps mod 256 like the counter
    end

    // registers of the shadow
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hc_q  <= 8'h00;
            inf_q <= 1'b0;
        end else begin
            hc_q  <= hc_d;
            inf_q <= inf_d;
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_rx;
        ce && rx_vld;
    endsequence

    property p_pass;
        s_rx |=> vld && hdr == $past(rx_hdr);
    endproperty
    property p_tc;
        s_rx ##0 !tc_vc_en[rx_hdr.tc] |=> vld && mal;
    endproperty
    property p_uns;
        s_rx ##0 rx_hdr.typ == prtec_pkg::TYP_TCFG && tc_vc_en[rx_hdr.tc]
            |=> unsup;
    endproperty
    property p_form;
        s_rx ##0 rx_hdr.typ == prtec_pkg::TYP_IO && rx_hdr.len != 10'h001
            |=> mal;
    endproperty
    property p_mps;
        s_rx ##0 rx_hdr.typ == prtec_pkg::TYP_CPL && rx_hdr.fmt == 3'h2
            && max_payload == 3'h0 && tc_vc_en[rx_hdr.tc]
            |=> mal == $past(rx_hdr.len > 10'h020 || rx_hdr.len == 10'h000);
    endproperty
    property p_hov;
        upd && fin && left > prtec_pkg::HDR_OUT_MAX |=> fc_err;
    endproperty
    property p_inf;
        upd && !fc_upd_init && inf_q && fc_hdr_lim != 8'h00 |=> fc_err;
    endproperty
    property p_quiet;
        !upd |=> !fc_err;
    endproperty
    property p_fci;
        upd && fc_upd_init |=> fci_vld && fci_hdr == $past(fc_hdr_lim);
    endproperty

    a_pass: assert property (p_pass) else $error("header not passed on");
    a_tc: assert property (p_tc) else $error("unmapped tc not malformed");
    a_uns: assert property (p_uns) else $error("type not unsupported");
    a_form: assert property (p_form) else $error("bad io length passed");
    a_mps: assert property (p_mps) else $error("payload size verdict");
    a_hov: assert property (p_hov) else $error("header credit excess");
    a_inf: assert property (p_inf) else $error("infinite credit dropped");
    a_quiet: assert property (p_quiet) else $error("stray credit error");
    a_fci: assert property (p_fci) else $error("advert not passed on");
endmodule

// ---- prtec_pkg.sv ----
// shared constants and header layout for the receive tlp error checks
// assumes both ends run on one clock and one reset
package prtec_pkg;

    // ****************************************************************
    // header fields carried from the protocol block to the user logic
    // ****************************************************************
    typedef struct packed {
        logic [2:0]  fmt;      // bit 2 prefix, bit 1 data, bit 0 4dw
        logic [4:0]  typ;
        logic [2:0]  tc;
        logic [9:0]  len;      // doublewords, zero means 1024
        logic [3:0]  fbe;
        logic [3:0]  lbe;
        logic [7:0]  tag;
        logic [2:0]  sts;      // completion status
        logic [6:0]  addr_lo;  // completion lower address
        logic [11:0] bcnt;     // completion byte count, zero means 4096
    } prtec_hdr_t;

    // ****************************************************************
    // type, format and status encodings
    // ****************************************************************
    localparam logic [4:0] TYP_MEM   = 5'h00;
    localparam logic [4:0] TYP_MEMLK = 5'h01;
    localparam logic [4:0] TYP_IO    = 5'h02;
    localparam logic [4:0] TYP_CFG0  = 5'h04;
    localparam logic [4:0] TYP_CFG1  = 5'h05;
    localparam logic [4:0] TYP_CPL   = 5'h0a;
    localparam logic [4:0] TYP_CPLLK = 5'h0b;
    localparam logic [4:0] TYP_FADD  = 5'h0c;
    localparam logic [4:0] TYP_CAS   = 5'h0e;
    localparam logic [4:0] TYP_TCFG  = 5'h1b;
    localparam logic [4:0] TYP_MSG_M = 5'h10;  // message types 10xxx

    localparam int FMT_PFX = 2;
    localparam int FMT_DAT = 1;
    localparam int FMT_4DW = 0;

    localparam logic [2:0] STS_SC  = 3'h0;
    localparam logic [2:0] STS_UR  = 3'h1;
    localparam logic [2:0] STS_CRS = 3'h2;
    localparam logic [2:0] STS_CA  = 3'h4;

    // ****************************************************************
    // size and credit limits
    // ****************************************************************
    localparam logic [12:0] MPS_BASE_B  = 13'h0080;  // 128 bytes at code 0
    localparam logic [2:0]  MPS_TOP     = 3'h5;      // 4096 bytes
    localparam logic [7:0]  HDR_OUT_MAX = 8'h7f;     // 127 header credits
    localparam logic [11:0] DAT_OUT_MAX = 12'h7ff;   // 2047 data credits
    localparam logic [11:0] DAT_MIN_B   = 12'h008;   // 128 bytes / 16
    localparam logic [2:0]  OWN_TC      = 3'h0;      // own requests use tc0

endpackage

// ---- prtec_usr_end.sv ----
// user-logic end: checks left to the application, completions for errors
// assumes the protocol block end drives lnk on the same mclk
`timescale 1ns/1ps

module prtec_usr_end #(
    parameter int unsigned TAG_W = 5
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    prtec_if.usr                  lnk,
    input  wire logic             chk_opt,
    input  wire logic             req_prog_viol,
    input  wire logic             req_dev_err,
    input  wire logic             req_issue,
    input  wire logic [TAG_W-1:0] req_tag,
    input  wire logic             req_is_cfg,
    input  wire logic             rcb_128,
    input  wire logic [2:0]       far_mps,
    output logic                  rx_acc,
    output logic                  rx_drop,
    output logic                  mal_err,
    output logic                  unexp_cpl,
    output logic                  cpl_err_rpt,
    output logic                  fc_err,
    output logic                  cpl_req,
    output logic [2:0]            cpl_sts,
    output logic [2:0]            cpl_tc,
    output logic [7:0]            cpl_tag,
    output logic [2:0]            req_tc
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (TAG_W < 1 || TAG_W > 8) begin : g_bad_tag
        $error("TAG_W must be 1 to 8");
    end

    localparam int unsigned NTAG = 1 << TAG_W;

    // ****************************************************************
    // header decode
    // ****************************************************************
    prtec_pkg::prtec_hdr_t h;
    logic             dat, is_cpl, is_mrd, is_np, known, last;
    logic [12:0]      len_b, bcnt_b;
    logic [6:0]       end_lo;
    logic [TAG_W-1:0] tg;
    logic             tag_hi, hit;
    logic             r01, r03, r04, r05, r06, r11, r13;

    logic [NTAG-1:0]  out_q, out_d, cfg_q, cfg_d;

    always_comb begin
        h      = lnk.hdr;
        dat    = h.fmt[prtec_pkg::FMT_DAT];
        len_b  = {(h.len == 10'h000), h.len, 2'b00};
        bcnt_b = {(h.bcnt == 12'h000), h.bcnt};
        is_cpl = (h.typ[4:1] == prtec_pkg::TYP_CPL[4:1]);
        is_mrd = !dat && (h.typ[4:1] == prtec_pkg::TYP_MEM[4:1]);
        is_np  = is_mrd || h.typ == prtec_pkg::TYP_IO
              || h.typ[4:1] == prtec_pkg::TYP_CFG0[4:1]
              || (dat && h.typ >= prtec_pkg::TYP_FADD
                      && h.typ <= prtec_pkg::TYP_CAS);
        known  = is_np || is_cpl || h.typ == prtec_pkg::TYP_MEM
              || h.typ == prtec_pkg::TYP_TCFG
              || h.typ[4:3] == prtec_pkg::TYP_MSG_M[4:3];
        // a completion is the last one once its data covers the count
        last   = !dat || bcnt_b <= len_b;
        end_lo = 7'(h.addr_lo + len_b[6:0]);
        tg     = h.tag[TAG_W-1:0];
        tag_hi = (8'(h.tag >> TAG_W) != 8'h00);
        hit    = out_q[tg] && !tag_hi;
        r01 = chk_opt && !h.fmt[prtec_pkg::FMT_PFX] && !known;
        r03 = dat && h.typ == prtec_pkg::TYP_MEMLK;
        r04 = is_cpl && dat && h.fmt[prtec_pkg::FMT_4DW];
        r05 = h.typ == prtec_pkg::TYP_IO
           && h.fmt[prtec_pkg::FMT_4DW];
        // one dword: last enables zero; longer: both sets non-zero
        r06 = is_mrd && ((h.len == 10'h001) ? (h.lbe != 4'h0)
           : (h.fbe == 4'h0 || h.lbe == 4'h0));
        // a partial completion must end on the boundary
        r11 = chk_opt && is_cpl && dat && !last
           && (rcb_128 ? end_lo != 7'h00 : end_lo[5:0] != 6'h00);
        r13 = chk_opt && is_cpl && hit && !cfg_q[tg]
           && h.sts == prtec_pkg::STS_CRS;
    end

    // ****************************************************************
    // outstanding request table
    // ****************************************************************
    // an issue in the same cycle as a retire wins, so no request is lost
    always_comb begin
        out_d = out_q;
        cfg_d = cfg_q;
        if (lnk.vld && is_cpl && hit && last) begin
            out_d[tg] = 1'b0;
        end
        if (req_issue) begin
            out_d[req_tag] = 1'b1;
            cfg_d[req_tag] = req_is_cfg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
            cfg_q <= '0;
        end else if (ce) begin
            out_q <= out_d;
            cfg_q <= cfg_d;
        end
    end

    // ****************************************************************
    // verdict and completion request
    // ****************************************************************
    logic       acc_q, acc_d, drop_q, drop_d, mal_q, mal_d;
    logic       unx_q, unx_d, rpt_q, rpt_d, fce_q, fce_d;
    logic       creq_q, creq_d;
    logic [2:0] csts_q, csts_d, ctc_q, ctc_d;
    logic [7:0] ctag_q, ctag_d;
    logic [11:0] dmin;
    logic       mal, unx, ca;

    // malformed non-posted and unsupported requests are answered with ur, so the
    // requester never waits for a timeout on a dropped packet
    always_comb begin
        mal    = lnk.mal || r01 || r03 || r04 || r05 || r06
              || r11 || r13;
        unx    = is_cpl && !hit;
        ca     = req_dev_err || (chk_opt && req_prog_viol);
        acc_d  = 1'b0;
        drop_d = 1'b0;
        mal_d  = 1'b0;
        unx_d  = 1'b0;
        rpt_d  = 1'b0;
        creq_d = 1'b0;
        csts_d = csts_q;
        ctc_d  = ctc_q;
        ctag_d = ctag_q;
        if (lnk.vld) begin
            mal_d  = mal;
            unx_d  = unx && !mal;
            drop_d = mal || unx;
            rpt_d  = is_cpl && hit && !mal
                  && (h.sts == prtec_pkg::STS_UR
                   || h.sts == prtec_pkg::STS_CA);
            if ((is_np && mal) || lnk.unsup) begin
                creq_d = 1'b1;
                csts_d = prtec_pkg::STS_UR;
            end else if (is_np && ca) begin
                creq_d = 1'b1;
                csts_d = prtec_pkg::STS_CA;
            end
            if (creq_d) begin
                ctc_d  = h.tc;
                ctag_d = h.tag;
            end
            acc_d = !drop_d && !creq_d;
        end
        // zero credits mean infinite and always pass
        dmin  = prtec_pkg::DAT_MIN_B << ((far_mps > prtec_pkg::MPS_TOP)
              ? prtec_pkg::MPS_TOP : far_mps);
        fce_d = chk_opt && lnk.fci_vld && lnk.fci_data != 12'h000
             && lnk.fci_data < dmin;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q  <= 1'b0;
            drop_q <= 1'b0;
            mal_q  <= 1'b0;
            unx_q  <= 1'b0;
            rpt_q  <= 1'b0;
            fce_q  <= 1'b0;
            creq_q <= 1'b0;
            csts_q <= prtec_pkg::STS_SC;
            ctc_q  <= 3'h0;
            ctag_q <= 8'h00;
        end else if (ce) begin
            acc_q  <= acc_d;
            drop_q <= drop_d;
            mal_q  <= mal_d;
            unx_q  <= unx_d;
            rpt_q  <= rpt_d;
            fce_q  <= fce_d;
            creq_q <= creq_d;
            csts_q <= csts_d;
            ctc_q  <= ctc_d;
            ctag_q <= ctag_d;
        end
    end

    assign rx_acc      = acc_q;
    assign rx_drop     = drop_q;
    assign mal_err     = mal_q;
    assign unexp_cpl   = unx_q;
    assign cpl_err_rpt = rpt_q;
    assign fc_err      = fce_q;
    assign cpl_req     = creq_q;
    assign cpl_sts     = csts_q;
    assign cpl_tc      = ctc_q;
    assign cpl_tag     = ctag_q;
    assign req_tc      = prtec_pkg::OWN_TC;

endmodule

// ---- tb_top.sv ----
// self-checking bench: both ends joined by prtec_if, monitor beside it
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ps

module tb_top;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic                  mclk, rst_n, ce, rx_vld, tx_hdr_use;
    prtec_pkg::prtec_hdr_t rx_hdr;
    logic [2:0]            max_payload, far_mps, cpl_sts, cpl_tc, req_tc;
    logic [7:0]            tc_vc_en, fc_hdr_lim, tx_data_use, cpl_tag;
    logic [11:0]           fc_data_lim;
    logic                  fc_upd_vld, fc_upd_init, fc_err_dev, fc_err_usr;
    logic                  chk_opt, req_prog_viol, req_dev_err, req_issue;
    logic [4:0]            req_tag;
    logic                  req_is_cfg, rcb_128, rx_acc, rx_drop, mal_err;
    logic                  unexp_cpl, cpl_err_rpt, cpl_req;
    int                    fail_count, checks;

    prtec_if i_prtec_if ();
    prtec_dev_end i_prtec_dev_end (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .rx_vld(rx_vld), .rx_hdr(rx_hdr), .max_payload(max_payload),
        .tc_vc_en(tc_vc_en), .fc_upd_vld(fc_upd_vld),
        .fc_upd_init(fc_upd_init), .fc_hdr_lim(fc_hdr_lim),
        .fc_data_lim(fc_data_lim), .tx_hdr_use(tx_hdr_use),
        .tx_data_use(tx_data_use), .fc_err(fc_err_dev), .lnk(i_prtec_if));
    prtec_usr_end #(.TAG_W(5)) i_prtec_usr_end (.mclk(mclk), .rst_n(rst_n),
        .ce(ce), .lnk(i_prtec_if), .chk_opt(chk_opt),
        .req_prog_viol(req_prog_viol), .req_dev_err(req_dev_err),
        .req_issue(req_issue), .req_tag(req_tag), .req_is_cfg(req_is_cfg),
        .rcb_128(rcb_128), .far_mps(far_mps), .rx_acc(rx_acc),
        .rx_drop(rx_drop), .mal_err(mal_err), .unexp_cpl(unexp_cpl),
        .cpl_err_rpt(cpl_err_rpt), .fc_err(fc_err_usr), .cpl_req(cpl_req),
        .cpl_sts(cpl_sts), .cpl_tc(cpl_tc), .cpl_tag(cpl_tag),
        .req_tc(req_tc));
    prtec_monitor i_prtec_monitor (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .rx_vld(rx_vld), .rx_hdr(rx_hdr), .max_payload(max_payload),
        .tc_vc_en(tc_vc_en), .fc_upd_vld(fc_upd_vld),
        .fc_upd_init(fc_upd_init), .fc_hdr_lim(fc_hdr_lim),
        .tx_hdr_use(tx_hdr_use), .fc_err(fc_err_dev),
        .vld(i_prtec_if.vld), .hdr(i_prtec_if.hdr), .mal(i_prtec_if.mal),
        .unsup(i_prtec_if.unsup), .fci_vld(i_prtec_if.fci_vld),
        .fci_hdr(i_prtec_if.fci_hdr));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // inputs move 1 ns after the edge
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic reset;
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
    endtask

    // v is {app verdict, cpl status, {acc,drop,mal,cpl,unexp,rpt}}
    task automatic rx(input logic [7:0] ft, input logic [2:0] tc,
        input logic [9:0] len, input logic [3:0] lbe, input logic [7:0] tag,
        input logic [2:0] sts, input logic [11:0] bc, input logic [10:0] v);
        rx_hdr = '{ft[7:5], ft[4:0], tc, len, 4'hf, lbe, tag, sts, 7'h00, bc};
        rx_vld = 1'b1;
        tick;
        rx_vld = 1'b0;
        {req_prog_viol, req_dev_err} = v[10:9];
        tick;
        {req_prog_viol, req_dev_err} = 2'h0;
        check(16'({rx_acc, rx_drop, mal_err, cpl_req, unexp_cpl,
                   cpl_err_rpt}), 16'(v[5:0]));
        if (v[2]) check(16'({cpl_sts, cpl_tc, cpl_tag}),
                        16'({v[8:6], tc, tag}));
    endtask

    task automatic issue(input logic [4:0] tag, input logic cfg);
        req_issue = 1'b1;
        req_tag = tag;
        req_is_cfg = cfg;
        tick;
        req_issue = 1'b0;
    endtask

    // credit advert; exp is {device error, user error}
    task automatic fc(input logic init, input logic [7:0] h,
                      input logic [11:0] d, input logic [1:0] exp);
        {fc_upd_vld, fc_upd_init} = {1'b1, init};
        {fc_hdr_lim, fc_data_lim} = {h, d};
        tick;
        fc_upd_vld = 1'b0;
        check(16'(fc_err_dev), 16'(exp[1]));
        tick;
        check(16'(fc_err_usr), 16'(exp[0]));
    endtask

    // ****************************************************************
    // clock, watchdog and tests
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // tests take ~100 cycles; 2500 means a hang
    initial begin
        repeat (2500) @(posedge mclk);
        fail_count++;
        print_verdict;
    end

    initial begin
        {rx_vld, rx_hdr, max_payload, far_mps, tx_hdr_use} = '0;
        {fc_upd_vld, fc_upd_init, fc_hdr_lim, fc_data_lim, tx_data_use} = '0;
        {req_prog_viol, req_dev_err, req_issue, req_tag, req_is_cfg} = '0;
        {rcb_128, tc_vc_en, fail_count, checks} = '0;
        ce = 1'b1;
        chk_opt = 1'b1;
        tc_vc_en = 8'hf7;  // tc3 has no enabled channel
        reset;
        rx(8'h42, 3'h0, 10'h002, 4'h0, 8'h01, 3'h0, 12'h000, 11'h05c);
        rx(8'h41, 3'h0, 10'h001, 4'h0, 8'h02, 3'h0, 12'h000, 11'h018);
        rx(8'h6a, 3'h0, 10'h001, 4'h0, 8'h00, 3'h0, 12'h004, 11'h018);
        rx(8'h22, 3'h0, 10'h001, 4'h0, 8'h03, 3'h0, 12'h000, 11'h05c);
        rx(8'h00, 3'h0, 10'h001, 4'h3, 8'h04, 3'h0, 12'h000, 11'h05c);
        rx(8'h00, 3'h3, 10'h001, 4'h0, 8'h05, 3'h0, 12'h000, 11'h05c);
        rx(8'h1b, 3'h0, 10'h001, 4'h0, 8'h06, 3'h0, 12'h000, 11'h044);
        rx(8'h05, 3'h0, 10'h001, 4'h0, 8'h07, 3'h0, 12'h000, 11'h044);
        rx(8'h00, 3'h0, 10'h001, 4'h0, 8'h08, 3'h0, 12'h000, 11'h504);
        rx(8'h00, 3'h5, 10'h001, 4'h0, 8'h15, 3'h0, 12'h000, 11'h304);
        rx(8'h00, 3'h6, 10'h001, 4'h0, 8'h16, 3'h0, 12'h000, 11'h020);
        check(12'(req_tc), 12'(prtec_pkg::OWN_TC));
        $display("test request checks done");
        issue(5'h04, 1'b0);
        rx(8'h4a, 3'h0, 10'h020, 4'h0, 8'h04, 3'h0, 12'h080, 11'h020);
        rx(8'h4a, 3'h0, 10'h020, 4'h0, 8'h04, 3'h0, 12'h080, 11'h012);
        rx(8'h0a, 3'h0, 10'h001, 4'h0, 8'h20, 3'h0, 12'h004, 11'h012);
        issue(5'h05, 1'b0);
        rx(8'h4a, 3'h0, 10'h021, 4'h0, 8'h05, 3'h0, 12'h084, 11'h018);
        issue(5'h06, 1'b0);
        rx(8'h4a, 3'h0, 10'h004, 4'h0, 8'h06, 3'h0, 12'h040, 11'h018);
        rx(8'h4a, 3'h0, 10'h010, 4'h0, 8'h06, 3'h0, 12'h080, 11'h020);
        rcb_128 = 1'b1;
        rx(8'h4a, 3'h0, 10'h010, 4'h0, 8'h06, 3'h0, 12'h080, 11'h018);
        issue(5'h07, 1'b0);
        rx(8'h0a, 3'h0, 10'h001, 4'h0, 8'h07, 3'h2, 12'h004, 11'h018);
        issue(5'h08, 1'b1);
        rx(8'h0a, 3'h0, 10'h001, 4'h0, 8'h08, 3'h2, 12'h004, 11'h020);
        issue(5'h09, 1'b0);
        rx(8'h0a, 3'h0, 10'h001, 4'h0, 8'h09, 3'h1, 12'h004, 11'h021);
        issue(5'h0a, 1'b0);
        rx(8'h0a, 3'h0, 10'h001, 4'h0, 8'h0a, 3'h4, 12'h004, 11'h021);
        $display("test completion checks done");
        fc(1'b1, 8'h04, 12'h004, 2'h1);
        chk_opt = 1'b0;
        fc(1'b1, 8'h04, 12'h004, 2'h0);
        chk_opt = 1'b1;
        fc(1'b1, 8'h04, 12'h008, 2'h0);
        fc(1'b1, 8'h80, 12'h008, 2'h2);
        fc(1'b1, 8'h7f, 12'h7ff, 2'h0);
        tx_hdr_use = 1'b1;
        tx_data_use = 8'h10;
        tick;
        tx_data_use = 8'h00;
        tick;
        tx_hdr_use = 1'b0;
        fc(1'b0, 8'h82, 12'h80f, 2'h2);
        fc(1'b0, 8'h81, 12'h80f, 2'h0);
        fc(1'b0, 8'h81, 12'h810, 2'h2);
        reset;
        fc(1'b1, 8'h00, 12'h064, 2'h0);
        fc(1'b0, 8'h05, 12'h064, 2'h2);
        fc(1'b0, 8'h00, 12'h064, 2'h0);
        fc(1'b1, 8'h0a, 12'h000, 2'h0);
        fc(1'b0, 8'h0a, 12'h003, 2'h2);
        $display("test flow control checks done");
        print_verdict;
    end
endmodule
